// file: rtl/fpw_flash_page.sv
`timescale 1ns/1ps
// How it works
// - Normal-mode boot with code zero secures flash, clears debug pin enable, blocks debug.
// - Each reset copies bit 0 of the nonvolatile option byte into the working option register.
// - Working option bits 7..1 read zero; bit 0 is the security code.
// - Working option register always readable; writes to it change nothing.
// - Code 0 means secured; secured flash reads zero to debug requesters only, CPU reads see the array.
// - High-voltage enable bit 3 settable only with program or erase select set.
// - Bulk erase select bit 2 selects a whole-array erase.
// - Program select bit 0 selects a program operation.
// - Program and erase selects never both one, nor set together by one write.
// - While secured, writes to program select are ignored.
// - Window 0x00c0..0x00ff reaches the 64-byte block chosen by page select.
// - Page bits form address 13..6; window offset gives bits 5..0.
// - Page 0x08 reaches the high-page registers 0x0200..0x023f.
// - Indexed data decodes only at 0x000e; reaches RAM 0x000e via index 0x0e, or 0xce with page zero.
// - With page zero, offsets c0..ce reach RAM 0..e; offset cf reaches index register.
module fpw_flash_page
    import fpw_pkg::*;
#(
    parameter int ADDR_W = 14
) (
    input wire logic clk, // 10 MHz system clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic modeSelectPin, // High at reset release: normal mode
    input wire logic debugRequester, // Current access comes from debug
    input wire fpw_req_t cpuReq, // CPU or debug byte access
    output fpw_mem_t memReq, // Translated access to memory
    input wire logic [7:0] memRdata, // Memory read data, same cycle
    output logic [7:0] cpuRdata, // Registered read data
    output logic securityEngaged, // Flash security active
    output logic debugBlocked, // Debug communication blocked
    output logic debugPinEnable, // Debug pin enable
    output logic programSelect, // Program operation selected
    output logic bulkEraseSelect, // Whole-array erase selected
    output logic highVoltageEnable, // Array high voltage on
    output logic [7:0] pageSelect, // Page select register
    output logic loading // Option fetch in progress
);

    fpw_state_t state, next_state;
    logic securityCode, next_securityCode;
    logic normalMode, next_normalMode;
    logic [7:0] flashControl, next_flashControl;
    logic [7:0] next_pageSelect;
    logic [7:0] indexReg, next_indexReg;
    logic [7:0] next_cpuRdata;
    logic debugPinEnableSet, next_debugPinEnableSet;
    logic [ADDR_W-1:0] target;
    logic inWindow, isFlash, hitCtl, hitPage, hitIdx, hitIdxData, hitOpt;
    logic [ADDR_W-1:0] effAddr;

    assign loading = (state == FPW_LOAD);
    assign securityEngaged = ~securityCode;
    assign debugBlocked = normalMode & ~securityCode;
    assign debugPinEnable = debugPinEnableSet & ~debugBlocked;
    assign programSelect = flashControl[PGM_BIT];
    assign bulkEraseSelect = flashControl[MASS_BIT];
    assign highVoltageEnable = flashControl[HV_BIT];

    // Window and indexed-data address translation
    always_comb begin
        target = {pageSelect, cpuReq.addr[WIN_OFS_W-1:0]};
        inWindow = (cpuReq.addr >= WINDOW_BASE) && (cpuReq.addr <= WINDOW_LAST);
        hitIdxData = (cpuReq.addr == INDEXED_DATA_ADDR);
        effAddr = cpuReq.addr;
        if (inWindow) begin
            effAddr = target;
        end else if (hitIdxData) begin
            effAddr = {6'h00, indexReg};
        end
        // Indexed target in the window is itself translated
        if (hitIdxData && (indexReg >= WINDOW_BASE[7:0])) begin
            effAddr = {pageSelect, indexReg[WIN_OFS_W-1:0]};
        end
        // Index 0x0e through indexed data returns the RAM byte, not itself
        if (hitIdxData && (indexReg == INDEXED_DATA_ADDR[7:0])) begin
            effAddr = INDEXED_DATA_ADDR;
        end
        hitIdx = (effAddr == INDEX_REG_ADDR) && !(hitIdxData && indexReg == INDEXED_DATA_ADDR[7:0]);
        hitOpt = (effAddr == FLASH_OPTION_WORKING_ADDR);
        hitCtl = (effAddr == FLASH_CONTROL_ADDR);
        hitPage = (effAddr == PAGE_SELECT_ADDR);
        isFlash = (effAddr >= 14'h3800);
        memReq.addr = effAddr;
        memReq.wdata = cpuReq.wdata;
        memReq.rd = (loading ? 1'b1 : cpuReq.rd) & ~hitIdx & ~hitOpt & ~hitCtl & ~hitPage;
        memReq.wr = ~loading & cpuReq.wr & ~hitIdx & ~hitOpt & ~hitCtl & ~hitPage;
        if (loading) begin
            memReq.addr = FLASH_OPTION_NONVOLATILE_ADDR;
            memReq.rd = 1'b1;
            memReq.wr = 1'b0;
        end
    end

    // Register next values
    always_comb begin
        logic [7:0] w;
        w = cpuReq.wdata & FLASH_CONTROL_MASK;
        next_state = state;
        next_securityCode = securityCode;
        next_normalMode = normalMode;
        next_flashControl = flashControl;
        next_pageSelect = pageSelect;
        next_indexReg = indexReg;
        next_debugPinEnableSet = debugPinEnableSet;
        next_cpuRdata = cpuRdata;
        case (state)
            FPW_LOAD: begin
                next_securityCode = memRdata[SEC_BIT];
                next_normalMode = modeSelectPin;
                next_debugPinEnableSet = ~modeSelectPin;
                next_state = FPW_RUN;
            end
            FPW_RUN: begin
                if (cpuReq.wr) begin
                    if (hitCtl) begin
                        if (securityEngaged) begin
                            w[PGM_BIT] = flashControl[PGM_BIT];
                        end
                        if (w[PGM_BIT] && w[MASS_BIT]) begin
                            w[PGM_BIT] = flashControl[PGM_BIT];
                            w[MASS_BIT] = flashControl[MASS_BIT];
                        end
                        if (w[PGM_BIT] && flashControl[MASS_BIT] && w[MASS_BIT]) begin
                            w[PGM_BIT] = 1'b0;
                        end
                        if (w[MASS_BIT] && flashControl[PGM_BIT] && w[PGM_BIT]) begin
                            w[MASS_BIT] = 1'b0;
                        end
                        if (w[HV_BIT] && !flashControl[HV_BIT] && !(w[PGM_BIT] || w[MASS_BIT])) begin
                            w[HV_BIT] = 1'b0;
                        end
                        next_flashControl = w;
                    end
                    if (hitPage) begin
                        next_pageSelect = cpuReq.wdata;
                    end
                    if (hitIdx) begin
                        next_indexReg = cpuReq.wdata;
                    end
                    // Writes to the working option fall through untouched
                end
                if (cpuReq.rd) begin
                    if (hitOpt) begin
                        next_cpuRdata = {7'h00, securityCode};
                    end else if (hitCtl) begin
                        next_cpuRdata = flashControl & FLASH_CONTROL_MASK;
                    end else if (hitPage) begin
                        next_cpuRdata = pageSelect;
                    end else if (hitIdx) begin
                        next_cpuRdata = indexReg;
                    end else if (isFlash && securityEngaged && debugRequester) begin
                        next_cpuRdata = 8'h00;
                    end else begin
                        next_cpuRdata = memRdata;
                    end
                end
            end
            default: next_state = FPW_LOAD;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= FPW_LOAD;
            securityCode <= 1'b0; // Secure until the option byte is seen
            normalMode <= 1'b1;
            flashControl <= FLASH_CONTROL_RST;
            pageSelect <= PAGE_SELECT_RST;
            indexReg <= INDEX_RST;
            debugPinEnableSet <= 1'b0;
            cpuRdata <= 8'h00;
        end else begin
            state <= next_state;
            securityCode <= next_securityCode;
            normalMode <= next_normalMode;
            flashControl <= next_flashControl;
            pageSelect <= next_pageSelect;
            indexReg <= next_indexReg;
            debugPinEnableSet <= next_debugPinEnableSet;
            cpuRdata <= next_cpuRdata;
        end
    end

    sequence ctlWrite_s;
        cpuReq.wr && hitCtl && !loading;
    endsequence

    // Arming writes that must take effect on the next edge
    sequence pgmArm_s;
        cpuReq.wr && hitCtl && !loading && !securityEngaged && cpuReq.wdata[PGM_BIT] && !cpuReq.wdata[MASS_BIT];
    endsequence

    sequence massArm_s;
        cpuReq.wr && hitCtl && !loading && cpuReq.wdata[MASS_BIT] && !cpuReq.wdata[PGM_BIT];
    endsequence

    interlock_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(programSelect && bulkEraseSelect)) else $error("program and erase both set");
    hv_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(highVoltageEnable) |-> (programSelect || bulkEraseSelect)) else $error("hv without select");
    secure_pgm_a: assert property (@(posedge clk) disable iff (!rst_n)
        securityEngaged && !loading |=> !$rose(programSelect)) else $error("program set while secured");
    opt_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        loading |=> (securityCode == $past(memRdata[SEC_BIT]))) else $error("option not loaded");
    opt_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
        !loading |=> $stable(securityCode)) else $error("option changed after load");
    debug_block_a: assert property (@(posedge clk) disable iff (!rst_n)
        debugBlocked |-> !debugPinEnable) else $error("debug pin enabled while blocked");
    ctl_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        ctlWrite_s |=> (flashControl[7:4] == 4'h0) && !flashControl[1]) else $error("unused control bits set");
    window_map_a: assert property (@(posedge clk) disable iff (!rst_n)
        inWindow && !loading |-> memReq.addr[5:0] == cpuReq.addr[5:0]) else $error("window offset wrong");
    secure_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpuReq.rd && isFlash && securityEngaged && debugRequester && !loading |=> cpuRdata == 8'h00)
        else $error("secured flash leaked");

    // Option register: one fetch, read-only view of the code
    load_once_a: assert property (@(posedge clk) disable iff (!rst_n)
        loading |=> !loading)
        else $error("option fetch repeated");

    opt_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpuReq.rd && hitOpt && !loading |=> cpuRdata == {7'h00, $past(securityCode)})
        else $error("option read wrong");

    opt_nowrite_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpuReq.wr && hitOpt |-> !memReq.wr)
        else $error("option write leaked");

    // Control register write rules
    pgm_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpuReq.wr && hitCtl && !loading && securityEngaged |=> programSelect == $past(programSelect))
        else $error("program changed while secured");

    both_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpuReq.wr && hitCtl && !loading && !securityEngaged && cpuReq.wdata[PGM_BIT] && cpuReq.wdata[MASS_BIT]
        |=> programSelect == $past(programSelect) && bulkEraseSelect == $past(bulkEraseSelect))
        else $error("double select accepted");

    mass_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        massArm_s and !programSelect |=> bulkEraseSelect)
        else $error("erase select not set");

    pgm_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        pgmArm_s and !bulkEraseSelect |=> programSelect)
        else $error("program select not set");

    hv_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
        ctlWrite_s and (cpuReq.wdata[HV_BIT] && !cpuReq.wdata[PGM_BIT] && !cpuReq.wdata[MASS_BIT]
        && !programSelect && !highVoltageEnable) |=> !highVoltageEnable)
        else $error("hv set without select");

    ctl_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpuReq.rd && hitCtl && !loading |=> cpuRdata == $past(flashControl))
        else $error("control read wrong");

    // Window and index mapping
    window_page_a: assert property (@(posedge clk) disable iff (!rst_n)
        inWindow && !loading |-> memReq.addr[13:6] == pageSelect)
        else $error("window page wrong");

    own_regs_a: assert property (@(posedge clk) disable iff (!rst_n)
        !loading && (hitCtl || hitPage || hitIdx || hitOpt) |-> !memReq.rd && !memReq.wr)
        else $error("own register reached memory");

    page_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpuReq.wr && hitPage && !loading |=> pageSelect == $past(cpuReq.wdata))
        else $error("page write lost");

    page_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpuReq.rd && hitPage && !loading |=> cpuRdata == $past(pageSelect))
        else $error("page read wrong");

    idx_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpuReq.wr && hitIdx && !loading |=> indexReg == $past(cpuReq.wdata))
        else $error("index write lost");

    idx_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpuReq.rd && hitIdx && !loading |=> cpuRdata == $past(indexReg))
        else $error("index read wrong");

    page_zero_idx_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpuReq.addr == 14'h00cf && pageSelect == 8'h00 && !loading |-> hitIdx)
        else $error("offset cf missed index");

    idx_data_a: assert property (@(posedge clk) disable iff (!rst_n)
        hitIdxData && indexReg == 8'h0e && !loading |-> memReq.addr == INDEXED_DATA_ADDR)
        else $error("indexed ram byte missed");

    idx_win_a: assert property (@(posedge clk) disable iff (!rst_n)
        hitIdxData && indexReg == 8'hce && pageSelect == 8'h00 && !loading |-> memReq.addr == INDEXED_DATA_ADDR)
        else $error("indexed window byte missed");

    // Outside normal mode the debug pin stays usable
    debug_open_a: assert property (@(posedge clk) disable iff (!rst_n)
        !normalMode && !loading |-> debugPinEnable && !debugBlocked)
        else $error("debug closed outside normal mode");

endmodule

// file: rtl/fpw_pkg.sv
package fpw_pkg;

    // Register addresses on the 14-bit CPU address space
    localparam logic [13:0] FLASH_OPTION_WORKING_ADDR = 14'h0210;
    localparam logic [13:0] FLASH_OPTION_NONVOLATILE_ADDR = 14'h3ffc;
    localparam logic [13:0] FLASH_CONTROL_ADDR = 14'h0211;
    localparam logic [13:0] PAGE_SELECT_ADDR = 14'h001f;
    localparam logic [13:0] INDEXED_DATA_ADDR = 14'h000e;
    localparam logic [13:0] INDEX_REG_ADDR = 14'h000f;
    localparam logic [13:0] WINDOW_BASE = 14'h00c0;
    localparam logic [13:0] WINDOW_LAST = 14'h00ff;

    // Field positions
    localparam int SEC_BIT = 0;
    localparam int PGM_BIT = 0;
    localparam int MASS_BIT = 2;
    localparam int HV_BIT = 3;
    localparam int WIN_OFS_W = 6;

    // Reset values and control write mask
    localparam logic [7:0] FLASH_CONTROL_RST = 8'h00;
    localparam logic [7:0] PAGE_SELECT_RST = 8'h00;
    localparam logic [7:0] INDEX_RST = 8'h00;
    localparam logic [7:0] FLASH_CONTROL_MASK = 8'h0d;

    // Cycles of option fetch after reset release
    localparam int LOAD_CYCLES = 1;

    typedef enum {FPW_LOAD, FPW_RUN} fpw_state_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [13:0] addr;
        logic [7:0] wdata;
    } fpw_req_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [13:0] addr;
        logic [7:0] wdata;
    } fpw_mem_t;

endpackage

// file: test/fpw_mem_model.sv
`timescale 1ns/1ps
module fpw_mem_model
    import fpw_pkg::*;
(
    input wire logic clk, // System clock
    input wire fpw_mem_t memReq, // Translated access
    input wire logic [7:0] optionByte, // Programmed option location
    output logic [7:0] memRdata // Read data, same cycle
);
    logic [7:0] mem [0:16383];
    initial begin
        for (int i = 0; i < 16384; i++) begin
            mem[i] = 8'(i) ^ 8'ha5;
        end
    end
    always_ff @(posedge clk) begin
        if (memReq.wr) begin
            mem[memReq.addr] <= memReq.wdata;
        end
    end
    always_comb begin
        if (!memReq.rd) begin
            memRdata = ~mem[memReq.addr]; // Idle bus never shows a usable byte
        end else if (memReq.addr == FLASH_OPTION_NONVOLATILE_ADDR) begin
            memRdata = optionByte;
        end else begin
            memRdata = mem[memReq.addr];
        end
    end
endmodule

// file: test/flash_control_and_page_window_bench.sv
`timescale 1ns/1ps
module flash_control_and_page_window_bench
    import fpw_pkg::*;
();
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic modeSelectPin = 1'b1;
    logic debugRequester = 1'b0;
    fpw_req_t cpuReq = '0;
    fpw_mem_t memReq;
    logic [7:0] memRdata, cpuRdata, pageSelect;
    logic [7:0] optionByte = 8'h00;
    logic securityEngaged, debugBlocked, debugPinEnable, programSelect, bulkEraseSelect, highVoltageEnable;
    logic loading;
    int errorCnt = 0;
    int compares = 0;
    int cycles = 0;

    always #50 clk = ~clk;

    fpw_flash_page i_fpw_flash_page (.clk(clk), .rst_n(rst_n), .modeSelectPin(modeSelectPin),
        .debugRequester(debugRequester), .cpuReq(cpuReq), .memReq(memReq), .memRdata(memRdata),
        .cpuRdata(cpuRdata), .securityEngaged(securityEngaged), .debugBlocked(debugBlocked),
        .debugPinEnable(debugPinEnable), .programSelect(programSelect), .bulkEraseSelect(bulkEraseSelect),
        .highVoltageEnable(highVoltageEnable), .pageSelect(pageSelect), .loading(loading));
    fpw_mem_model i_fpw_mem_model (.clk(clk), .memReq(memReq), .optionByte(optionByte), .memRdata(memRdata));

    task automatic printVerdict();
        $display("Comparisons %0d, mismatches %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errorCnt++;
            printVerdict();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errorCnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One request cycle, released on the next edge
    task automatic acc(input logic dbg, input logic w, input logic [13:0] a, input logic [7:0] d);
        @(posedge clk);
        cpuReq <= '{rd: !w, wr: w, addr: a, wdata: d};
        debugRequester <= dbg;
        @(posedge clk);
        cpuReq <= '0;
        debugRequester <= 1'b0;
        @(negedge clk);
    endtask
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        acc(1'b0, 1'b1, a, d);
    endtask
    task automatic rd(input logic dbg, input logic [13:0] a, input logic [7:0] exp);
        acc(dbg, 1'b0, a, 8'h00);
        chk(cpuRdata, exp);
    endtask
    task automatic boot(input logic [7:0] opt, input logic ms);
        @(posedge clk);
        optionByte <= opt;
        modeSelectPin <= ms;
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    initial begin
        boot(8'h00, 1'b1);
        chk({2'b00, securityEngaged, debugBlocked, debugPinEnable, 2'b00, loading}, 8'h30);
        rd(1'b0, FLASH_OPTION_WORKING_ADDR, 8'h00);
        wr(FLASH_OPTION_WORKING_ADDR, 8'hff);
        rd(1'b0, FLASH_OPTION_WORKING_ADDR, 8'h00);
        wr(FLASH_CONTROL_ADDR, 8'h01);
        rd(1'b0, FLASH_CONTROL_ADDR, 8'h00);
        rd(1'b1, 14'h3801, 8'h00);
        boot(8'hff, 1'b1);
        chk({6'h00, securityEngaged, debugBlocked}, 8'h00);
        rd(1'b0, FLASH_OPTION_WORKING_ADDR, 8'h01);
        rd(1'b1, 14'h3801, 8'ha4);
        rd(1'b0, PAGE_SELECT_ADDR, 8'h00);
        wr(FLASH_CONTROL_ADDR, 8'h05);
        rd(1'b0, FLASH_CONTROL_ADDR, 8'h00);
        wr(FLASH_CONTROL_ADDR, 8'hf3);
        rd(1'b0, FLASH_CONTROL_ADDR, 8'h01);
        wr(FLASH_CONTROL_ADDR, 8'h09);
        chk({7'h00, highVoltageEnable}, 8'h01);
        wr(FLASH_CONTROL_ADDR, 8'h00);
        wr(FLASH_CONTROL_ADDR, 8'h08);
        rd(1'b0, FLASH_CONTROL_ADDR, 8'h00);
        wr(FLASH_CONTROL_ADDR, 8'h04);
        chk({6'h00, bulkEraseSelect, programSelect}, 8'h02);
        wr(PAGE_SELECT_ADDR, 8'hff);
        chk(pageSelect, 8'hff);
        wr(14'h00c5, 8'h3c);
        chk(i_fpw_mem_model.mem[14'h3fc5], 8'h3c);
        rd(1'b0, 14'h00c5, 8'h3c);
        wr(PAGE_SELECT_ADDR, 8'h08);
        rd(1'b0, 14'h00d0, 8'h01);
        wr(PAGE_SELECT_ADDR, 8'h00);
        wr(14'h00ce, 8'h77);
        chk(i_fpw_mem_model.mem[14'h000e], 8'h77);
        wr(INDEX_REG_ADDR, 8'h0e);
        rd(1'b0, INDEXED_DATA_ADDR, 8'h77);
        wr(INDEX_REG_ADDR, 8'hce);
        rd(1'b0, INDEXED_DATA_ADDR, 8'h77);
        rd(1'b0, 14'h00cf, 8'hce);
        boot(8'h00, 1'b0);
        chk({4'h0, securityEngaged, debugBlocked, debugPinEnable, loading}, 8'h0a);
        rd(1'b1, 14'h3801, 8'h00);
        printVerdict();
    end
endmodule
